// ---- verilog/sfrws_pkg.sv ----
// Purpose: shared constants and types of the serial flash erase / row write host sequencer
// Assumes: 40 MHz system clock, 32-bit classic Wishbone register port
// Notes: instruction words are 24 bits, command codes 4 bits, both sent lsb first
package sfrws_pkg;
  // system clock and link timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int LINK_HALF_NS = 100;
  localparam int LINK_HALF_CYC = (LINK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // link framing: 4 command bits then 24 data bits, or 4 + 8 idle + 16 readout bits
  localparam int CMD_BITS = 4;
  localparam int DATA_BITS = 24;
  localparam int FRAME_BITS = CMD_BITS + DATA_BITS;
  localparam int READ_IDLE_BITS = 8;
  localparam int READ_BITS = 16;
  localparam int READ_FIRST_BIT = CMD_BITS + READ_IDLE_BITS;
  // command codes
  localparam logic [3:0] CMD_EXEC = 4'h0;
  localparam logic [3:0] CMD_READOUT = 4'h1;
  // core instruction words
  localparam logic [23:0] OP_NOP = 24'h000000;
  localparam logic [23:0] OP_GOTO_SAFE = 24'h040200;
  localparam logic [23:0] OP_NVM_ERASE_TO_SCRATCH = 24'h24064a;
  localparam logic [23:0] OP_NVM_ROW_TO_SCRATCH = 24'h24004a;
  localparam logic [23:0] OP_SCRATCH_TO_NVM = 24'h883b0a;
  localparam logic [23:0] OP_W0_TO_PAGE = 24'h880190;
  localparam logic [23:0] OP_DUMMY_TABLE_WRITE = 24'hbb0800;
  localparam logic [23:0] OP_START_BIT_SET = 24'ha8e761;
  localparam logic [23:0] OP_NVM_TO_W2 = 24'h803b02;
  localparam logic [23:0] OP_W2_TO_READOUT = 24'h883c22;
  localparam logic [23:0] OP_CLEAR_READ_PTR = 24'heb0300;
  localparam logic [23:0] OP_TW_LOW = 24'hbb0bb6;
  localparam logic [23:0] OP_TW_HIGH_POST = 24'hbbdbb6;
  localparam logic [23:0] OP_TW_HIGH_PRE = 24'hbbebb6;
  localparam logic [23:0] OP_TW_LOW_POST = 24'hbb1bb6;
  localparam logic [3:0] MOV_LIT_OPC = 4'h2;
  localparam logic [3:0] REG_W0 = 4'h0;
  localparam logic [3:0] REG_WRITE_PTR = 4'h7;
  // nvm control register start bit
  localparam int NVM_START_BIT = 15;
  // row geometry
  localparam int ROW_WORDS = 32;
  localparam int GROUP_WORDS = 4;
  localparam int ROW_GROUPS = ROW_WORDS / GROUP_WORDS;
  localparam logic [23:0] GROUP_ADDR_STEP = 24'h000008;
  // sequence phase lengths in items
  localparam logic [4:0] LEN_EXIT = 5'h03;
  localparam logic [4:0] LEN_NVM = 5'h02;
  localparam logic [4:0] LEN_ERPAGE = 5'h06;
  localparam logic [4:0] LEN_ADDR = 5'h03;
  localparam logic [4:0] LEN_PACK = 5'h06;
  localparam logic [4:0] LEN_LATCH = 5'h1a;
  localparam logic [4:0] LEN_START = 5'h03;
  localparam logic [4:0] LEN_POLL = 5'h08;
  localparam logic [4:0] LEN_PCRST = 5'h02;
  localparam logic [4:0] POLL_READ_IDX = 5'h06;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_PTR = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_NVMVAL = 8'h14;
  // control and status fields
  localparam int CTRL_ERASE = 0;
  localparam int CTRL_ROW = 1;
  localparam int CTRL_CLR_DONE = 2;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_POLLS_LSB = 16;
  // states
  typedef enum {LK_IDLE, LK_LOW, LK_HIGH} sfrws_link_state_t;
  typedef enum {PH_IDLE, PH_EXIT, PH_NVM, PH_ERPAGE, PH_ADDR, PH_PACK, PH_LATCH, PH_START, PH_POLL,
    PH_PCRST} sfrws_phase_t;
endpackage

// ---- verilog/sfrws_link.sv ----
// Purpose: bit-level driver of the programming clock and data pins for one frame
// Assumes: start only while ready; progDataIn is asynchronous to clk
// Notes: the link clock is made here by dividing clk; readout frames release the data pin
`timescale 1ns/1ps
module sfrws_link
  import sfrws_pkg::*;
#(
  parameter int HALF_CYC = LINK_HALF_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic [3:0] cmdCode,
  input wire logic [23:0] cmdData,
  output logic ready,
  output logic done,
  output logic [15:0] readWord,
  output logic progClockOut,
  output logic progDataOut,
  output logic progDataOe,
  input wire logic progDataIn
);
  sfrws_link_state_t state_ff;
  logic [7:0] divCnt_ff;
  logic [4:0] bitIdx_ff;
  logic [27:0] frame_ff;
  logic rdMode_ff;
  logic pgdMeta_ff;
  logic pgdSync_ff;
  logic [15:0] readSh_ff;
  logic pgc_ff;
  logic pgd_ff;
  logic oe_ff;
  logic done_ff;
  logic [15:0] readWord_ff;
  logic halfEnd;
  logic lastBit;

  assign halfEnd = (divCnt_ff == 8'(HALF_CYC - 1));
  assign lastBit = (bitIdx_ff == 5'(FRAME_BITS - 1));
  assign ready = (state_ff == LK_IDLE);
  assign done = done_ff;
  assign readWord = readWord_ff;
  assign progClockOut = pgc_ff;
  assign progDataOut = pgd_ff;
  assign progDataOe = oe_ff;

  // two-stage synchroniser for the returning data pin
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pgdMeta_ff <= 1'b0;
      pgdSync_ff <= 1'b0;
    end else begin
      pgdMeta_ff <= progDataIn;
      pgdSync_ff <= pgdMeta_ff;
    end
  end

  // frame sequencing: data set as the clock falls, held across the rising edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_ff <= LK_IDLE;
      divCnt_ff <= 8'h00;
      bitIdx_ff <= 5'h00;
      frame_ff <= 28'h0000000;
      rdMode_ff <= 1'b0;
      pgc_ff <= 1'b0;
      pgd_ff <= 1'b0;
      oe_ff <= 1'b1;
    end else begin
      case (state_ff)
        LK_IDLE: begin
          if (start) begin
            frame_ff <= {cmdData, cmdCode}; // command first, lsb first [RULE_01]
            rdMode_ff <= (cmdCode == CMD_READOUT);
            bitIdx_ff <= 5'h00;
            divCnt_ff <= 8'h00;
            pgd_ff <= cmdCode[0];
            oe_ff <= 1'b1;
            state_ff <= LK_LOW;
          end
        end
        LK_LOW: begin
          if (halfEnd) begin
            divCnt_ff <= 8'h00;
            pgc_ff <= 1'b1; // rising edge: device samples [RULE_15]
            state_ff <= LK_HIGH;
          end else begin
            divCnt_ff <= divCnt_ff + 8'h01;
          end
        end
        LK_HIGH: begin
          if (halfEnd) begin
            divCnt_ff <= 8'h00;
            pgc_ff <= 1'b0;
            if (lastBit) begin
              state_ff <= LK_IDLE;
            end else begin
              bitIdx_ff <= bitIdx_ff + 5'h01;
              pgd_ff <= frame_ff[bitIdx_ff + 5'h01]; // change on falling edge [RULE_15]
              if (rdMode_ff && (bitIdx_ff == 5'(CMD_BITS - 1))) begin
                oe_ff <= 1'b0; // hand the pin to the device after the code [RULE_12]
              end
              state_ff <= LK_LOW;
            end
          end else begin
            divCnt_ff <= divCnt_ff + 8'h01;
          end
        end
        default: state_ff <= LK_IDLE;
      endcase
    end
  end

  // readout capture at the end of each high phase, lsb first
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      readSh_ff <= 16'h0000;
      readWord_ff <= 16'h0000;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (state_ff == LK_HIGH && halfEnd) begin
        if (rdMode_ff && bitIdx_ff >= 5'(READ_FIRST_BIT)) begin
          readSh_ff <= {pgdSync_ff, readSh_ff[15:1]}; // [RULE_12]
        end
        if (lastBit) begin
          done_ff <= 1'b1;
          readWord_ff <= rdMode_ff ? {pgdSync_ff, readSh_ff[15:1]} : readSh_ff;
        end
      end
    end
  end

  property p_first_bit;
    @(posedge clk) disable iff (sys_rst) (start && ready) |=> (progDataOut == $past(cmdCode[0])) && progDataOe;
  endproperty
  a_first_bit: assert property (p_first_bit) else $error("first link bit is not command lsb"); // [RULE_01]

  property p_data_still_at_rise;
    @(posedge clk) disable iff (sys_rst) $rose(progClockOut) |-> $stable(progDataOut);
  endproperty
  a_data_still_at_rise: assert property (p_data_still_at_rise) else $error("data moved at clock rise"); // [RULE_15]

  property p_data_moves_low;
    @(posedge clk) disable iff (sys_rst) $changed(progDataOut) |-> !progClockOut;
  endproperty
  a_data_moves_low: assert property (p_data_moves_low) else $error("data changed while clock high"); // [RULE_15]

  property p_released_in_readout;
    @(posedge clk) disable iff (sys_rst)
      (state_ff != LK_IDLE && rdMode_ff && bitIdx_ff >= 5'(CMD_BITS)) |-> !progDataOe;
  endproperty
  a_released_in_readout: assert property (p_released_in_readout) else $error("pin driven during readout"); // [RULE_12]
endmodule

// ---- verilog/sfrws_host.sv ----
// Purpose: host sequencer that bulk-erases and writes code rows of a serially programmed flash
// Assumes: device already in programming mode; software fills the row buffer before a row write
// Notes: one row per command; software steps the address from row to row
// Functional notes
// RULE_01: codes and words go out lsb first
// RULE_02: nop, goto 0x200, nop before each operation
// RULE_03: row write loads control 0x4004 via scratch
// RULE_04: address upper byte to page, low 16 pointer
// RULE_05: four words packed into six holding registers
// RULE_06: clear read pointer, eight table writes, nops
// RULE_07: device programs 32-word rows from latches
// RULE_08: address, pack, latch steps repeated eight times
// RULE_09: set start bit, poll until bit 15 clears
// RULE_10: reset program counter to 200h after row
// RULE_11: repeat per row for whole code memory
// RULE_12: poll copies control to readout, code 0001
// RULE_13: erase: 0x4064, page, dummy write, start, poll
// RULE_14: device idles 8, then shifts 16 bits
// RULE_15: data changes falling, sampled rising clock edge
// RULE_16: device self-times erase and write operations
//
// Implementation choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
module sfrws_host
  import sfrws_pkg::*;
#(
  parameter int HALF_CYC = LINK_HALF_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic progClockOut,
  output logic progDataOut,
  output logic progDataOe,
  input wire logic progDataIn
);
  sfrws_phase_t phase_ff;
  logic [4:0] idx_ff;
  logic [2:0] group_ff;
  logic eraseMode_ff;
  logic inFlight_ff;
  logic doneFlag_ff;
  logic [15:0] lastNvm_ff;
  logic [15:0] polls_ff;
  logic [23:0] rowAddr_ff;
  logic [4:0] ptr_ff;
  logic [23:0] rowBuf_ff [ROW_WORDS];
  logic ack_ff;
  logic [31:0] datOut_ff;
  logic busWr;
  logic busRd;
  logic [31:0] wrWord;
  logic linkReady;
  logic linkDone;
  logic [15:0] linkWord;
  logic itemStart;
  logic [3:0] itemCmd;
  logic [23:0] itemData;
  logic [4:0] phaseLen;
  logic phaseLast;
  logic [23:0] groupAddr;
  logic [23:0] gw0;
  logic [23:0] gw1;
  logic [23:0] gw2;
  logic [23:0] gw3;
  logic [4:0] latchPos;
  logic [2:0] twNum;

  // bus access strobes: a write completes on the edge that samples ack, a read is taken one edge earlier
  assign busWr = cyc_i && stb_i && we_i && ack_ff;
  assign busRd = cyc_i && stb_i && !we_i && !ack_ff;
  assign ack_o = ack_ff;
  assign dat_o = datOut_ff;
  assign wrWord = {sel_i[3] ? dat_i[31:24] : 8'h00, sel_i[2] ? dat_i[23:16] : 8'h00,
    sel_i[1] ? dat_i[15:8] : 8'h00, sel_i[0] ? dat_i[7:0] : 8'h00};

  // mov literal instruction into a working register
  function automatic logic [23:0] movLit(input logic [15:0] lit, input logic [3:0] regNum);
    movLit = {MOV_LIT_OPC, lit, regNum};
  endfunction

  // wishbone classic slave: ack one cycle after the request, dropped after one cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= cyc_i && stb_i && !ack_ff;
    end
  end

  // read data, registered with ack; unmapped offsets read zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      datOut_ff <= 32'h00000000;
    end else if (busRd) begin
      case (adr_i)
        REG_ADDR: datOut_ff <= {8'h00, rowAddr_ff};
        REG_DATA: datOut_ff <= {8'h00, rowBuf_ff[ptr_ff]};
        REG_PTR: datOut_ff <= {27'h0000000, ptr_ff};
        REG_STATUS: datOut_ff <= {polls_ff, 14'h0000, doneFlag_ff, phase_ff != PH_IDLE};
        REG_NVMVAL: datOut_ff <= {16'h0000, lastNvm_ff};
        default: datOut_ff <= 32'h00000000;
      endcase
    end else begin
      datOut_ff <= 32'h00000000;
    end
  end

  // row address and row buffer, frozen while an operation runs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rowAddr_ff <= 24'h000000;
      ptr_ff <= 5'h00;
    end else if (busWr && phase_ff == PH_IDLE) begin
      if (adr_i == REG_ADDR) begin
        rowAddr_ff <= wrWord[23:0];
      end
      if (adr_i == REG_PTR) begin
        ptr_ff <= wrWord[4:0];
      end
      if (adr_i == REG_DATA) begin
        ptr_ff <= ptr_ff + 5'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (busWr && phase_ff == PH_IDLE && adr_i == REG_DATA) begin
      rowBuf_ff[ptr_ff] <= wrWord[23:0];
    end
  end

  // current group of four row words and its destination
  assign groupAddr = rowAddr_ff + 24'(group_ff) * GROUP_ADDR_STEP;
  assign gw0 = rowBuf_ff[{group_ff, 2'h0}];
  assign gw1 = rowBuf_ff[{group_ff, 2'h1}];
  assign gw2 = rowBuf_ff[{group_ff, 2'h2}];
  assign gw3 = rowBuf_ff[{group_ff, 2'h3}];
  assign latchPos = idx_ff - 5'h02;
  assign twNum = 3'(latchPos / 5'h03);

  // item generator: command code and instruction word for the current step
  always_comb begin
    itemCmd = CMD_EXEC;
    itemData = OP_NOP;
    case (phase_ff)
      PH_EXIT: itemData = (idx_ff == 5'h01) ? OP_GOTO_SAFE : OP_NOP; // [RULE_02]
      PH_NVM: begin
        if (idx_ff == 5'h00) begin
          itemData = eraseMode_ff ? OP_NVM_ERASE_TO_SCRATCH : OP_NVM_ROW_TO_SCRATCH; // [RULE_03] [RULE_13]
        end else begin
          itemData = OP_SCRATCH_TO_NVM;
        end
      end
      PH_ERPAGE: begin
        case (idx_ff)
          5'h00: itemData = movLit({8'h00, rowAddr_ff[23:16]}, REG_W0); // [RULE_13]
          5'h01: itemData = OP_W0_TO_PAGE;
          5'h02: itemData = movLit(16'h0000, REG_W0);
          5'h03: itemData = OP_DUMMY_TABLE_WRITE; // [RULE_13]
          default: itemData = OP_NOP;
        endcase
      end
      PH_ADDR: begin
        case (idx_ff)
          5'h00: itemData = movLit({8'h00, groupAddr[23:16]}, REG_W0); // [RULE_04]
          5'h01: itemData = OP_W0_TO_PAGE;
          default: itemData = movLit(groupAddr[15:0], REG_WRITE_PTR); // [RULE_04]
        endcase
      end
      PH_PACK: begin
        case (idx_ff)
          5'h00: itemData = movLit(gw0[15:0], 4'h0); // [RULE_05]
          5'h01: itemData = movLit({gw1[23:16], gw0[23:16]}, 4'h1);
          5'h02: itemData = movLit(gw1[15:0], 4'h2);
          5'h03: itemData = movLit(gw2[15:0], 4'h3);
          5'h04: itemData = movLit({gw3[23:16], gw2[23:16]}, 4'h4);
          default: itemData = movLit(gw3[15:0], 4'h5);
        endcase
      end
      PH_LATCH: begin
        if (idx_ff == 5'h00) begin
          itemData = OP_CLEAR_READ_PTR; // [RULE_06]
        end else if (idx_ff >= 5'h02 && latchPos == 5'(twNum) * 5'h03) begin
          case (twNum[1:0])
            2'h0: itemData = OP_TW_LOW; // [RULE_06]
            2'h1: itemData = OP_TW_HIGH_POST;
            2'h2: itemData = OP_TW_HIGH_PRE;
            default: itemData = OP_TW_LOW_POST;
          endcase
        end else begin
          itemData = OP_NOP;
        end
      end
      PH_START: itemData = (idx_ff == 5'h00) ? OP_START_BIT_SET : OP_NOP; // [RULE_09]
      PH_POLL: begin
        case (idx_ff)
          5'h01: itemData = OP_GOTO_SAFE;
          5'h03: itemData = OP_NVM_TO_W2; // [RULE_12]
          5'h04: itemData = OP_W2_TO_READOUT;
          5'h06: itemCmd = CMD_READOUT; // [RULE_12]
          default: itemData = OP_NOP;
        endcase
      end
      PH_PCRST: itemData = (idx_ff == 5'h00) ? OP_GOTO_SAFE : OP_NOP; // [RULE_10]
      default: itemData = OP_NOP;
    endcase
  end

  // phase lengths
  always_comb begin
    case (phase_ff)
      PH_EXIT: phaseLen = LEN_EXIT;
      PH_NVM: phaseLen = LEN_NVM;
      PH_ERPAGE: phaseLen = LEN_ERPAGE;
      PH_ADDR: phaseLen = LEN_ADDR;
      PH_PACK: phaseLen = LEN_PACK;
      PH_LATCH: phaseLen = LEN_LATCH;
      PH_START: phaseLen = LEN_START;
      PH_POLL: phaseLen = LEN_POLL;
      PH_PCRST: phaseLen = LEN_PCRST;
      default: phaseLen = 5'h01;
    endcase
  end
  assign phaseLast = (idx_ff == phaseLen - 5'h01);
  assign itemStart = (phase_ff != PH_IDLE) && linkReady && !inFlight_ff;

  // one item outstanding on the link at a time
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      inFlight_ff <= 1'b0;
    end else if (itemStart) begin
      inFlight_ff <= 1'b1;
    end else if (linkDone) begin
      inFlight_ff <= 1'b0;
    end
  end

  // operation sequencer: steps through the phases as each item completes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phase_ff <= PH_IDLE;
      idx_ff <= 5'h00;
      group_ff <= 3'h0;
      eraseMode_ff <= 1'b0;
    end else if (phase_ff == PH_IDLE) begin
      if (busWr && adr_i == REG_CTRL && (wrWord[CTRL_ERASE] || wrWord[CTRL_ROW])) begin
        eraseMode_ff <= wrWord[CTRL_ERASE];
        idx_ff <= 5'h00;
        group_ff <= 3'h0;
        phase_ff <= PH_EXIT; // [RULE_02]
      end
    end else if (linkDone) begin
      idx_ff <= phaseLast ? 5'h00 : idx_ff + 5'h01;
      if (phaseLast) begin
        case (phase_ff)
          PH_EXIT: phase_ff <= PH_NVM;
          PH_NVM: phase_ff <= eraseMode_ff ? PH_ERPAGE : PH_ADDR;
          PH_ERPAGE: phase_ff <= PH_START;
          PH_ADDR: phase_ff <= PH_PACK;
          PH_PACK: phase_ff <= PH_LATCH;
          PH_LATCH: begin
            group_ff <= group_ff + 3'h1;
            phase_ff <= (group_ff == 3'(ROW_GROUPS - 1)) ? PH_START : PH_ADDR; // [RULE_08]
          end
          PH_START: phase_ff <= PH_POLL;
          PH_POLL: begin
            if (lastNvm_ff[NVM_START_BIT]) begin
              phase_ff <= PH_POLL; // [RULE_09]
            end else begin
              phase_ff <= eraseMode_ff ? PH_IDLE : PH_PCRST; // [RULE_10]
            end
          end
          default: phase_ff <= PH_IDLE; // row finished, software moves to the next [RULE_11]
        endcase
      end
    end
  end

  // polled control value, poll count and done flag; completion beats a clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lastNvm_ff <= 16'h0000;
      polls_ff <= 16'h0000;
      doneFlag_ff <= 1'b0;
    end else begin
      if (linkDone && phase_ff == PH_POLL && idx_ff == POLL_READ_IDX) begin
        lastNvm_ff <= linkWord; // [RULE_12]
        polls_ff <= polls_ff + 16'h0001;
      end
      if (linkDone && phaseLast && (phase_ff == PH_PCRST ||
          (phase_ff == PH_POLL && eraseMode_ff && !lastNvm_ff[NVM_START_BIT]))) begin
        doneFlag_ff <= 1'b1; // [RULE_09]
      end else if (busWr && adr_i == REG_CTRL && wrWord[CTRL_CLR_DONE]) begin
        doneFlag_ff <= 1'b0;
      end
    end
  end

  sfrws_link #(
    .HALF_CYC(HALF_CYC)
  ) u_link (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(itemStart),
    .cmdCode(itemCmd),
    .cmdData(itemData),
    .ready(linkReady),
    .done(linkDone),
    .readWord(linkWord),
    .progClockOut(progClockOut),
    .progDataOut(progDataOut),
    .progDataOe(progDataOe),
    .progDataIn(progDataIn)
  );

  property p_exit_goto;
    @(posedge clk) disable iff (sys_rst) (itemStart && phase_ff == PH_EXIT) |->
      itemData == ((idx_ff == 5'h01) ? OP_GOTO_SAFE : OP_NOP);
  endproperty
  a_exit_goto: assert property (p_exit_goto) else $error("reset vector exit item wrong"); // [RULE_02]

  property p_row_nvm_value;
    @(posedge clk) disable iff (sys_rst) (itemStart && phase_ff == PH_NVM && idx_ff == 5'h00 && !eraseMode_ff)
      |-> itemData == OP_NVM_ROW_TO_SCRATCH;
  endproperty
  a_row_nvm_value: assert property (p_row_nvm_value) else $error("row write control value wrong"); // [RULE_03]

  property p_erase_nvm_value;
    @(posedge clk) disable iff (sys_rst) (itemStart && phase_ff == PH_NVM && idx_ff == 5'h00 && eraseMode_ff)
      |-> itemData == OP_NVM_ERASE_TO_SCRATCH;
  endproperty
  a_erase_nvm_value: assert property (p_erase_nvm_value) else $error("erase control value wrong"); // [RULE_13]

  property p_addr_split;
    @(posedge clk) disable iff (sys_rst) (itemStart && phase_ff == PH_ADDR && idx_ff == 5'h02)
      |-> itemData[19:4] == groupAddr[15:0] && itemData[3:0] == REG_WRITE_PTR;
  endproperty
  a_addr_split: assert property (p_addr_split) else $error("write pointer load wrong"); // [RULE_04]

  // a latch group that loops back for more must not have wrapped the group count
  property p_eight_groups;
    @(posedge clk) disable iff (sys_rst) ($past(phase_ff) == PH_LATCH && phase_ff == PH_ADDR && !$past(sys_rst))
      |-> group_ff != 3'h0 && group_ff == $past(group_ff) + 3'h1;
  endproperty
  a_eight_groups: assert property (p_eight_groups) else $error("latch group count out of range"); // [RULE_08]

  property p_start_after_all;
    @(posedge clk) disable iff (sys_rst) (phase_ff == PH_START && $past(phase_ff) == PH_LATCH)
      |-> group_ff == 3'h0 && $past(group_ff) == 3'(ROW_GROUPS - 1);
  endproperty
  a_start_after_all: assert property (p_start_after_all) else $error("write started before row filled"); // [RULE_08]

  property p_done_when_clear;
    @(posedge clk) disable iff (sys_rst) $rose(doneFlag_ff) |-> !lastNvm_ff[NVM_START_BIT] && phase_ff == PH_IDLE;
  endproperty
  a_done_when_clear: assert property (p_done_when_clear) else $error("done while start bit set"); // [RULE_09]

  property p_pc_reset_after_row;
    @(posedge clk) disable iff (sys_rst) ($past(phase_ff) == PH_POLL && phase_ff != PH_POLL && !eraseMode_ff &&
      !$past(sys_rst)) |-> phase_ff == PH_PCRST;
  endproperty
  a_pc_reset_after_row: assert property (p_pc_reset_after_row) else $error("no pc reset after row"); // [RULE_10]

  property p_readout_code;
    @(posedge clk) disable iff (sys_rst) (itemStart && itemCmd == CMD_READOUT)
      |-> phase_ff == PH_POLL && idx_ff == POLL_READ_IDX;
  endproperty
  a_readout_code: assert property (p_readout_code) else $error("readout code out of place"); // [RULE_12]
endmodule

// ---- sim/sfrws_dev_model.sv ----
// Purpose: device end of the programming link, enough to run erase and row write sequences
// Assumes: 4+24 bit frames clocked by pc, lsb first
// Notes: self-timed busy lasts BUSY_CLKS link clocks
`timescale 1ns/1ps
module sfrws_dev_model #(parameter int BUSY_CLKS = 300) (
  input wire logic pc,
  input wire logic hostOut,
  input wire logic hostOe,
  output logic pin
);
  logic [27:0] sr, nx;
  logic [15:0] w [16];
  logic [15:0] nvm, visi;
  logic [7:0] page;
  logic [4:0] cnt;
  logic rd, dOe, dOut;
  int busy, tw;
  // a released pin shows the inverse of the last driven level
  assign pin = hostOe ? hostOut : dOe ? dOut : ~dOut;
  initial begin
    cnt = 0; rd = 0; dOe = 0; dOut = 0; busy = 0; tw = 0; nvm = 0; page = 0; visi = 0;
  end
  // bits taken on the rising edge, lsb first; frame decoded at its last bit
  always @(posedge pc) begin
    nx = {pin, sr[27:1]};
    sr <= nx;
    dOe <= dOe && cnt >= 12; // held until the first rise of the next frame
    if (cnt == 3) rd <= (nx[27:24] == 4'h1);
    if (busy == 1) nvm[15] <= 1'b0;
    if (busy > 0) busy <= busy - 1;
    cnt <= (cnt == 27) ? 5'h00 : cnt + 5'h01;
    if (cnt == 27) rd <= 1'b0;
    if (cnt == 27 && !rd) begin
      if (nx[27:24] == 4'h2) w[nx[7:4]] <= nx[23:8];
      case (nx[27:4])
        24'h883b0a: nvm <= w[10];
        24'h880190: page <= w[0][7:0];
        24'h803b02: w[2] <= nvm;
        24'h883c22: visi <= w[2];
        24'ha8e761: begin nvm[15] <= 1'b1; busy <= BUSY_CLKS; end
        default: if (nx[27:20] == 8'hbb) tw <= tw + 1;
      endcase
    end
  end
  // readout driven from the falling edge after the idle clocks
  always @(negedge pc) if (rd && cnt >= 12) begin
    dOe <= 1'b1;
    dOut <= visi[cnt - 5'd12];
  end
endmodule

// ---- sim/serial_flash_erase_row_write_sequencer_tb.sv ----
// Purpose: self-checking bench of the host sequencer against the device model
// Assumes: HALF_CYC 3 shortens frames
// Notes: register reads by table, sequences by hand
`timescale 1ns/1ps
module serial_flash_erase_row_write_sequencer_tb;
  import sfrws_pkg::*;
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; $display("BAD t=%0t %h %h", $time, a, b); end end
  logic clk = 0, sys_rst = 1, cyc = 0, stb = 0, we = 0, ack, pc, pOut, pOe, pin;
  logic [7:0] adr = 0;
  logic [3:0] sel = 0;
  logic [31:0] dat = 0, dato, q;
  int n_fail = 0, n_checks = 0, cyc_n = 0;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} sfrws_row_t;
  sfrws_row_t rows [9] = '{'{0, REG_STATUS, 0, 0}, '{0, REG_NVMVAL, 0, 0}, '{1, REG_ADDR, 32'hff123440, 0},
    '{0, REG_ADDR, 0, 32'h123440}, '{1, REG_PTR, 32'h25, 0}, '{0, REG_PTR, 0, 5}, '{1, 8'h20, 1, 0},
    '{0, 8'h20, 0, 0}, '{0, REG_CTRL, 0, 0}};
  sfrws_host #(.HALF_CYC(3)) i_dut (.clk(clk), .sys_rst(sys_rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dato), .ack_o(ack), .progClockOut(pc),
    .progDataOut(pOut), .progDataOe(pOe), .progDataIn(pin));
  sfrws_dev_model i_dev (.pc(pc), .hostOut(pOut), .hostOe(pOe), .pin(pin));
  initial forever #12.5 clk = ~clk;
  // one classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d; sel <= s;
    do @(posedge clk); while (ack !== 1'b1);
    q = dato;
    cyc <= 0; stb <= 0;
    @(posedge clk);
  endtask
  task automatic wait_done();
    do wb(0, REG_STATUS, 0); while (q[STAT_DONE] !== 1'b1);
  endtask
  task automatic report_and_stop();
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // cycle ceiling cuts a hang short
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 90000) begin n_fail++; report_and_stop(); end
  end
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 0;
    @(posedge clk);
    wb(1, REG_ADDR, 32'hffffffff, 4'h2);
    wb(0, REG_ADDR, 0);
    `CHK(q, 32'h00ff00)
    foreach (rows[i]) begin
      wb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) `CHK(q, rows[i].e)
    end
    wb(1, REG_PTR, 0);
    for (int i = 0; i < 32; i++) wb(1, REG_DATA, 32'h800000 + i * 32'h010203);
    wb(0, REG_PTR, 0);
    `CHK(q, 32'h0)
    wb(1, REG_CTRL, 32'h2);
    wb(0, REG_STATUS, 0);
    `CHK(q[STAT_BUSY], 1'b1)
    wb(1, REG_ADDR, 0);
    wait_done();
    `CHK(q[31:16] > 1, 1'b1)
    wb(0, REG_ADDR, 0);
    `CHK(q, 32'h123440)
    wb(0, REG_NVMVAL, 0);
    `CHK(q, 32'h4004)
    `CHK(i_dev.tw, 64)
    `CHK(i_dev.page, 8'h12)
    `CHK(i_dev.w[7], 16'h3478)
    `CHK(i_dev.w[4], {8'h9f, 8'h9e})
    `CHK(i_dev.w[5], 16'h3e5d)
    wb(1, REG_CTRL, 32'h4);
    wb(0, REG_STATUS, 0);
    `CHK(q[STAT_DONE], 1'b0)
    wb(1, REG_CTRL, 32'h3);
    wait_done();
    wb(0, REG_NVMVAL, 0);
    `CHK(q, 32'h4064)
    `CHK(i_dev.tw, 65)
    // reset in the middle of an erase must abort it and clear status
    wb(1, REG_CTRL, 32'h1);
    repeat (500) @(posedge clk);
    sys_rst <= 1;
    @(posedge clk);
    sys_rst <= 0;
    @(posedge clk);
    `CHK({pc, pOut, pOe}, 3'b001)
    wb(0, REG_STATUS, 0);
    `CHK(q, 32'h0)
    report_and_stop();
  end
endmodule
